//--- logic/tmbg_pkg.sv
// package: constants and types shared by the timer end and the controller end
// Notes on behaviour
// - run bit plus mode bits pick timer mode
// - transmit clock from other timer or ours
// - receive clock chosen likewise, independently
// - baud mode rollover reloads count from reload
// - serial bit rate is overflow rate over 16
// - baud mode counts osc, or osc/2 in 12-clock
// - other modes count once per machine cycle
// - internal baud rate osc/(16*(65536-reload)) in 6-clock, osc/(32*(65536-reload)) in 12-clock
// - baud mode rollover sets no overflow flag
// - baud mode trigger edge sets flag, no reload
// - software avoids count access in baud mode
// - software avoids reload writes in baud mode
// - software stops timer before register access
// - non-baud setups need run bit set separately
// - documented control byte values per setup
// - trigger disabled: capture/reload on overflow only
// - trigger enabled: falling edge also captures/reloads
// - trigger flag sticky until software clears
// - count ticks or external pin falling edges
package tmbg_pkg;
   // control byte bit positions
   localparam int CTL_CAPTURE  = 0;
   localparam int CTL_COUNTER  = 1;
   localparam int CTL_RUN      = 2;
   localparam int CTL_TRIG_EN  = 3;
   localparam int CTL_TX_CLK   = 4;
   localparam int CTL_RX_CLK   = 5;
   localparam int CTL_TRIG_FLG = 6;
   localparam int CTL_OVF_FLG  = 7;
   localparam logic [7:0]  CTL_RESET    = 8'h00;
   localparam logic [15:0] COUNT_RESET  = 16'h0000;
   localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
   // oscillator clocks per tick
   localparam int OSC_PER_MC6   = 6;
   localparam int OSC_PER_MC12  = 12;
   localparam int OSC_PER_BAUD6 = 1;
   localparam int OSC_PER_BAUD12 = 2;
   localparam logic [3:0] DIV_ONE = 4'h1;
   localparam int BAUD_DIVISOR  = 16;
   // device register selects
   typedef enum logic [2:0] {
      TMBG_SEL_CTL, TMBG_SEL_CNT_LO, TMBG_SEL_CNT_HI,
      TMBG_SEL_RLD_LO, TMBG_SEL_RLD_HI
   } tmbg_sel_t;
   typedef enum logic [1:0] {
      TMBG_OFF, TMBG_RELOAD, TMBG_CAPTURE, TMBG_BAUD
   } tmbg_mode_t;
   // setup control values
   localparam logic [7:0] SETUP_BAUD_BOTH_INT = 8'h34;
   localparam logic [7:0] SETUP_BAUD_BOTH_EXT = 8'h36;
   localparam logic [7:0] SETUP_BAUD_RX_INT   = 8'h24;
   localparam logic [7:0] SETUP_BAUD_RX_EXT   = 8'h26;
   localparam logic [7:0] SETUP_BAUD_TX_INT   = 8'h14;
   localparam logic [7:0] SETUP_BAUD_TX_EXT   = 8'h16;
   localparam logic [7:0] SETUP_RELOAD_INT    = 8'h00;
   localparam logic [7:0] SETUP_RELOAD_EXT    = 8'h08;
   localparam logic [7:0] SETUP_CAPTURE_INT   = 8'h01;
   localparam logic [7:0] SETUP_CAPTURE_EXT   = 8'h09;
   // controller register map, word addresses on axi4-lite
   localparam logic [7:0] AXI_CTL     = 8'h00;
   localparam logic [7:0] AXI_RELOAD  = 8'h04;
   localparam logic [7:0] AXI_COUNT   = 8'h08;
   localparam logic [7:0] AXI_STATUS  = 8'h0C;
   localparam logic [7:0] AXI_CMD     = 8'h10;
   localparam logic [7:0] AXI_CAPTURE = 8'h14;
   localparam int CMD_APPLY_CTL = 0;
   localparam int CMD_APPLY_RLD = 1;
   localparam int CMD_APPLY_CNT = 2;
   localparam int CMD_CLR_OVF   = 3;
   localparam int CMD_CLR_TRIG  = 4;
   localparam int CMD_READ      = 5;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : tmbg_pkg

//--- logic/tmbg_if.sv
// interface joining the timer end and its controller end
`timescale 1ns/1ps
interface tmbg_if;
   import tmbg_pkg::*;
   logic        wr_stb;
   logic        rd_stb;
   tmbg_sel_t   sel;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        rvalid;
   logic        clr_ovf;
   logic        clr_trig;
   logic        irq;
   modport timer (input wr_stb, rd_stb, sel, wdata, clr_ovf, clr_trig,
                  output rdata, rvalid, irq);
   modport ctrl  (output wr_stb, rd_stb, sel, wdata, clr_ovf, clr_trig,
                  input rdata, rvalid, irq);
endinterface : tmbg_if

//--- logic/tmbg_timer.sv
// timer/counter with auto-reload, capture and baud generator modes
`timescale 1ns/1ps
module tmbg_timer (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   // controller side
   tmbg_if.timer     bus,
   // pins and strap
   input  wire logic count_input_pin,
   input  wire logic trigger_input,
   input  wire logic twelve_clock_mode,
   // serial clocking
   input  wire logic other_timer_ovf,
   output logic      tx_clk_pulse,
   output logic      rx_clk_pulse,
   output logic      timer_ovf_pulse
);
   import tmbg_pkg::*;

   logic [7:0]  ctl_q;
   logic [15:0] count_q, reload_q;
   logic [7:0]  rdata_q;
   logic        rvalid_q;
   logic [1:0]  cnt_sync_q, trg_sync_q;
   logic        cnt_last_q, trg_last_q;
   logic [3:0]  div_q;
   logic        tx_q, rx_q, ovf_q;

   // pins pass two flops before use
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_sync_q <= 2'b11;
         trg_sync_q <= 2'b11;
         cnt_last_q <= 1'b1;
         trg_last_q <= 1'b1;
      end else begin
         cnt_sync_q <= {cnt_sync_q[0], count_input_pin};
         trg_sync_q <= {trg_sync_q[0], trigger_input};
         cnt_last_q <= cnt_sync_q[1];
         trg_last_q <= trg_sync_q[1];
      end
   end

   wire pin_fall  = cnt_last_q & ~cnt_sync_q[1];
   wire trig_fall = trg_last_q & ~trg_sync_q[1];

   wire run       = ctl_q[CTL_RUN];
   wire baud      = ctl_q[CTL_TX_CLK] | ctl_q[CTL_RX_CLK];
   tmbg_mode_t mode;
   assign mode = !run ? TMBG_OFF :
                 baud ? TMBG_BAUD :
                 ctl_q[CTL_CAPTURE] ? TMBG_CAPTURE : TMBG_RELOAD;

   // tick divider: the core clock stands in for the oscillator
   localparam logic [3:0] DIV_MC6  = 4'(OSC_PER_MC6);
   localparam logic [3:0] DIV_MC12 = 4'(OSC_PER_MC12);
   localparam logic [3:0] DIV_B6   = 4'(OSC_PER_BAUD6);
   localparam logic [3:0] DIV_B12  = 4'(OSC_PER_BAUD12);
   wire [3:0] div_len = baud ? (twelve_clock_mode ? DIV_B12 : DIV_B6)
                             : (twelve_clock_mode ? DIV_MC12 : DIV_MC6);
   wire div_end = (div_q >= div_len - DIV_ONE);
   wire osc_tick = run & div_end;
   wire tick = ctl_q[CTL_COUNTER] ? (run & pin_fall) : osc_tick;

   wire rollover = tick & (count_q == COUNT_MAX);
   wire trig_ev  = run & ctl_q[CTL_TRIG_EN] & trig_fall;
   wire do_reload  = (mode == TMBG_RELOAD || mode == TMBG_BAUD) && rollover
                   || (mode == TMBG_RELOAD && trig_ev);
   wire do_capture = (mode == TMBG_CAPTURE) && trig_ev;
   wire set_ovf  = rollover && mode != TMBG_BAUD;
   wire wr_ctl   = bus.wr_stb && bus.sel == TMBG_SEL_CTL;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         div_q <= 4'h0;
      else if (!run || div_end)
         div_q <= 4'h0;
      else
         div_q <= div_q + DIV_ONE;
   end

   // count and reload registers; hardware reload or capture beats a software write, which beats a count tick
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         count_q  <= COUNT_RESET;
         reload_q <= COUNT_RESET;
      end else begin
         if (do_reload)
            count_q <= reload_q;
         else if (bus.wr_stb && bus.sel == TMBG_SEL_CNT_LO)
            count_q[7:0] <= bus.wdata;
         else if (bus.wr_stb && bus.sel == TMBG_SEL_CNT_HI)
            count_q[15:8] <= bus.wdata;
         else if (tick)
            count_q <= count_q + 16'h0001;
         if (do_capture)
            reload_q <= count_q;
         else if (bus.wr_stb && bus.sel == TMBG_SEL_RLD_LO)
            reload_q[7:0] <= bus.wdata;
         else if (bus.wr_stb && bus.sel == TMBG_SEL_RLD_HI)
            reload_q[15:8] <= bus.wdata;
      end
   end

   // control byte; hardware set beats software clear on flags
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         ctl_q <= CTL_RESET;
      else begin
         if (wr_ctl)
            ctl_q <= bus.wdata;
         if (bus.clr_ovf)
            ctl_q[CTL_OVF_FLG] <= 1'b0;
         if (bus.clr_trig)
            ctl_q[CTL_TRIG_FLG] <= 1'b0;
         if (set_ovf)
            ctl_q[CTL_OVF_FLG] <= 1'b1;
         if (trig_ev)
            ctl_q[CTL_TRIG_FLG] <= 1'b1;
      end
   end

   // overflow pulses steered to the serial clocks
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_q  <= 1'b0;
         rx_q  <= 1'b0;
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= rollover;
         tx_q  <= ctl_q[CTL_TX_CLK] ? rollover : other_timer_ovf;
         rx_q  <= ctl_q[CTL_RX_CLK] ? rollover : other_timer_ovf;
      end
   end

   // register reads, one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      unique case (bus.sel)
         TMBG_SEL_CTL:    rd_mux = ctl_q;
         TMBG_SEL_CNT_LO: rd_mux = count_q[7:0];
         TMBG_SEL_CNT_HI: rd_mux = count_q[15:8];
         TMBG_SEL_RLD_LO: rd_mux = reload_q[7:0];
         TMBG_SEL_RLD_HI: rd_mux = reload_q[15:8];
         default:         rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= bus.rd_stb;
         if (bus.rd_stb)
            rdata_q <= rd_mux;
      end
   end

   assign bus.rdata  = rdata_q;
   assign bus.rvalid = rvalid_q;
   assign bus.irq    = ctl_q[CTL_OVF_FLG] | ctl_q[CTL_TRIG_FLG];
   assign tx_clk_pulse    = tx_q;
   assign rx_clk_pulse    = rx_q;
   assign timer_ovf_pulse = ovf_q;
   // serial rate is these pulses over BAUD_DIVISOR, done in the UART
endmodule : tmbg_timer

//--- logic/tmbg_ctrl.sv
// axi4-lite controller that drives the timer end
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module tmbg_ctrl (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // timer side
   tmbg_if.ctrl             tmr,
   output logic             timer_irq
);
   import tmbg_pkg::*;

   typedef enum logic [2:0] {
      TMBG_IDLE, TMBG_WR, TMBG_RD, TMBG_RD_WAIT
   } tmbg_seq_t;

   logic [7:0]  ctl_q;
   logic [15:0] reload_q, count_q, snap_q, cap_q;
   logic [2:0]  pend_q;
   logic        rd_req_q;
   tmbg_seq_t   st_q;
   tmbg_sel_t   idx_q;
   logic        aw_q, w_q, bvalid_q, rvalid_q;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [1:0]  bresp_q, rresp_q;

   wire busy = (st_q != TMBG_IDLE) || (|pend_q) || rd_req_q;
   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready  = !w_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   wire do_wr = aw_q && w_q && !bvalid_q;
   wire wr_ok = (awaddr_q == AXI_CTL) || (awaddr_q == AXI_RELOAD)
             || (awaddr_q == AXI_COUNT) || (awaddr_q == AXI_CMD);
   wire [15:0] lo16 = wdata_q[15:0];

   // write channel; apply and read commands are dropped while a sequence runs
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b0;
         awaddr_q <= 8'h00; wdata_q <= 32'h0; bresp_q <= RESP_OKAY;
         ctl_q <= CTL_RESET; reload_q <= COUNT_RESET; count_q <= COUNT_RESET;
         pend_q <= 3'b000; rd_req_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_q <= 1'b0; w_q <= 1'b0; bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_q == AXI_CTL && s_axi_wstrb[0])
               ctl_q <= wdata_q[7:0];
            if (awaddr_q == AXI_RELOAD)
               reload_q <= lo16;
            if (awaddr_q == AXI_COUNT)
               count_q <= lo16;
            if (awaddr_q == AXI_CMD && !busy) begin
               pend_q <= {wdata_q[CMD_APPLY_CNT], wdata_q[CMD_APPLY_RLD],
                          wdata_q[CMD_APPLY_CTL]};
               rd_req_q <= wdata_q[CMD_READ];
            end
         end else if (s_axi_bvalid && s_axi_bready)
            bvalid_q <= 1'b0;
         if (st_q == TMBG_IDLE) begin
            if (pend_q != 3'b000)
               pend_q <= 3'b000;
            else if (rd_req_q)
               rd_req_q <= 1'b0;
         end
      end
   end

   // sequencer: writes count halves, reload halves, then ctl, or reads all
   logic [2:0] step_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= TMBG_IDLE; step_q <= 3'h0; idx_q <= TMBG_SEL_CTL;
         snap_q <= COUNT_RESET;
         cap_q <= COUNT_RESET;
      end else begin
         unique case (st_q)
            TMBG_IDLE: begin
               step_q <= 3'h0;
               if (pend_q != 3'b000)
                  st_q <= TMBG_WR;
               else if (rd_req_q)
                  st_q <= TMBG_RD;
            end
            TMBG_WR: begin
               step_q <= step_q + 3'h1;
               if (step_q == 3'h4)
                  st_q <= TMBG_IDLE;
            end
            TMBG_RD: begin
               idx_q <= tmbg_sel_t'(step_q);
               st_q <= TMBG_RD_WAIT;
            end
            TMBG_RD_WAIT: if (tmr.rvalid) begin
               if (idx_q == TMBG_SEL_CNT_LO) snap_q[7:0] <= tmr.rdata;
               if (idx_q == TMBG_SEL_CNT_HI) snap_q[15:8] <= tmr.rdata;
               if (idx_q == TMBG_SEL_RLD_LO) cap_q[7:0] <= tmr.rdata;
               if (idx_q == TMBG_SEL_RLD_HI) cap_q[15:8] <= tmr.rdata;
               step_q <= step_q + 3'h1;
               st_q <= (step_q == 3'h4) ? TMBG_IDLE : TMBG_RD;
            end
            default: st_q <= TMBG_IDLE;
         endcase
      end
   end

   tmbg_sel_t wsel;
   // control goes last, so count and reload load before the new control byte takes effect
   assign wsel = (step_q == 3'h4) ? TMBG_SEL_CTL
                                  : tmbg_sel_t'(step_q + 3'h1);
   logic [2:0] wr_mask_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) wr_mask_q <= 3'b000;
      else if (st_q == TMBG_IDLE) wr_mask_q <= pend_q;
   end
   wire mask_en = (wsel == TMBG_SEL_CTL) ? wr_mask_q[0] :
                  (wsel == TMBG_SEL_RLD_LO || wsel == TMBG_SEL_RLD_HI)
                  ? wr_mask_q[1] : wr_mask_q[2];

   assign tmr.wr_stb = (st_q == TMBG_WR) && mask_en;
   assign tmr.rd_stb = (st_q == TMBG_RD);
   assign tmr.sel    = (st_q == TMBG_WR) ? wsel : tmbg_sel_t'(step_q);
   assign tmr.wdata  = (wsel == TMBG_SEL_CTL)    ? ctl_q :
                       (wsel == TMBG_SEL_CNT_LO) ? count_q[7:0] :
                       (wsel == TMBG_SEL_CNT_HI) ? count_q[15:8] :
                       (wsel == TMBG_SEL_RLD_LO) ? reload_q[7:0] :
                       reload_q[15:8];
   wire cmd_fire = do_wr && awaddr_q == AXI_CMD;
   assign tmr.clr_ovf  = cmd_fire && wdata_q[CMD_CLR_OVF];
   assign tmr.clr_trig = cmd_fire && wdata_q[CMD_CLR_TRIG];
   assign timer_irq = tmr.irq;

   // read channel
   wire [31:0] rd_word =
      (s_axi_araddr == AXI_CTL)     ? {24'h0, ctl_q} :
      (s_axi_araddr == AXI_RELOAD)  ? {16'h0, reload_q} :
      (s_axi_araddr == AXI_COUNT)   ? {16'h0, snap_q} :
      (s_axi_araddr == AXI_STATUS)  ? {30'h0, busy, tmr.irq} :
      (s_axi_araddr == AXI_CAPTURE) ? {16'h0, cap_q} : 32'h0;
   wire rd_ok = (s_axi_araddr == AXI_CTL) || (s_axi_araddr == AXI_RELOAD)
             || (s_axi_araddr == AXI_COUNT) || (s_axi_araddr == AXI_STATUS)
             || (s_axi_araddr == AXI_CAPTURE) || (s_axi_araddr == AXI_CMD);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rvalid_q <= 1'b0; rdata_q <= 32'h0; rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;
endmodule : tmbg_ctrl

//--- sim/tmbg_checker.sv
// checker: timing relations on the link between controller and timer
`timescale 1ns/1ps
module tmbg_checker (
   // clock and reset
   input wire logic                core_clk,
   input wire logic                reset_n,
   // timer link
   input wire logic                wr_stb,
   input wire logic                rd_stb,
   input wire tmbg_pkg::tmbg_sel_t sel,
   input wire logic                rvalid,
   input wire logic                clr_ovf,
   input wire logic                clr_trig,
   input wire logic                irq
);
   import tmbg_pkg::*;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   read_answer_a: assert property (rd_stb |=> rvalid)
      else $error("read strobe got no answer");
   answer_cause_a: assert property (rvalid |-> $past(rd_stb))
      else $error("answer without a read strobe");
   strobe_excl_a: assert property (!(wr_stb && rd_stb))
      else $error("read and write strobes together");
   sel_range_a: assert property ((wr_stb || rd_stb) |-> sel <= TMBG_SEL_RLD_HI)
      else $error("strobe with unmapped select");
   flag_sticky_a: assert property ($fell(irq) |->
      $past(clr_ovf || clr_trig || wr_stb))
      else $error("flag dropped without a clear");
   ovf_clear_pulse_a: assert property (clr_ovf |=> !clr_ovf)
      else $error("overflow clear longer than one cycle");
   trig_clear_pulse_a: assert property (clr_trig |=> !clr_trig)
      else $error("trigger clear longer than one cycle");
   write_walk_a: assert property (wr_stb ##1 wr_stb |-> !$stable(sel))
      else $error("same select written twice in a row");
endmodule : tmbg_checker

//--- sim/tmbg_tb_top.sv
// testbench: both ends joined, driven over axi4-lite
`timescale 1ns/1ps
module tmbg_tb_top;
   import tmbg_pkg::*;
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic [7:0]  awaddr   = 8'h00;
   logic [7:0]  araddr   = 8'h00;
   logic [31:0] wdata    = 32'h00000000;
   logic        awvalid  = 1'b0;
   logic        wvalid   = 1'b0;
   logic        bready   = 1'b0;
   logic        arvalid  = 1'b0;
   logic        rready   = 1'b0;
   logic        pin      = 1'b1;
   logic        trig     = 1'b1;
   logic        twelve   = 1'b0;
   logic        oth      = 1'b0;
   logic        win      = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        tx_p, rx_p, ovf_p, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   int          n_ovf, n_tx, n_rx;
   int          miscompares = 0;
   int          checks_done = 0;

   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) if (win) begin
      n_ovf += int'(ovf_p);
      n_tx  += int'(tx_p);
      n_rx  += int'(rx_p);
   end

   tmbg_if i_tmbg_if ();
   tmbg_timer i_tmbg_timer (.core_clk(core_clk), .reset_n(reset_n),
      .bus(i_tmbg_if), .count_input_pin(pin), .trigger_input(trig),
      .twelve_clock_mode(twelve), .other_timer_ovf(oth),
      .tx_clk_pulse(tx_p), .rx_clk_pulse(rx_p), .timer_ovf_pulse(ovf_p));
   tmbg_ctrl i_tmbg_ctrl (.core_clk(core_clk), .reset_n(reset_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .tmr(i_tmbg_if), .timer_irq(irq));
   tmbg_checker i_tmbg_checker (.core_clk(core_clk), .reset_n(reset_n),
      .wr_stb(i_tmbg_if.wr_stb), .rd_stb(i_tmbg_if.rd_stb),
      .sel(i_tmbg_if.sel), .rvalid(i_tmbg_if.rvalid),
      .clr_ovf(i_tmbg_if.clr_ovf), .clr_trig(i_tmbg_if.clr_trig),
      .irq(i_tmbg_if.irq));

   task automatic chk(input string nm, input logic [31:0] e, g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // pulse counts may slip by one at the window edges
   task automatic near(input string nm, input int e, g);
      checks_done++;
      if (g < e - 1 || g > e + 1) begin
         miscompares++;
         $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
      end
   endtask : near

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge core_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      r = bresp;
      bready <= 1'b0;
      chk("bvalid", 32'h00000001, 32'(bvalid));
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk("rvalid", 32'h00000001, 32'(rvalid));
   endtask : axi_rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk("bresp", 32'(RESP_OKAY), 32'(r));
   endtask : wr

   // an apply or read command issued while busy is dropped, so wait for idle
   task automatic cmd(input logic [31:0] v);
      logic [31:0] d;
      logic [1:0]  r;
      wr(AXI_CMD, v);
      repeat (20) begin
         axi_rd(AXI_STATUS, d, r);
         if (d[1] === 1'b0) break;
      end
      chk("busy", 32'h00000000, 32'(d[1]));
   endtask : cmd

   task automatic cfg(input logic [7:0] c, input logic tw);
      wr(AXI_CTL, 32'h00000000);
      cmd(32'h00000001);
      cmd(32'h00000018);
      chk("irq cleared", 32'h00000000, 32'(irq));
      twelve <= tw;
      wr(AXI_RELOAD, 32'h0000FFF0);
      wr(AXI_COUNT, 32'h0000FFF0);
      wr(AXI_CTL, 32'(c));
      cmd(32'h00000007);
   endtask : cfg

   task automatic run(input logic [7:0] c, input logic tw, input int eo,
                      input bit tx_own, rx_own, input logic ei);
      cfg(c, tw);
      n_ovf = 0;
      n_tx  = 0;
      n_rx  = 0;
      repeat (200) @(posedge core_clk);
      win <= 1'b1;
      for (int i = 0; i < 960; i++) begin
         @(posedge core_clk);
         oth  <= (i % 40 == 20);
         pin  <= (i % 20 < 10);
         trig <= (i % 50 < 25);
      end
      win  <= 1'b0;
      oth  <= 1'b0;
      pin  <= 1'b1;
      trig <= 1'b1;
      near("overflows", eo, n_ovf);
      near("tx pulses", tx_own ? eo : 24, n_tx);
      near("rx pulses", rx_own ? eo : 24, n_rx);
      chk("irq", 32'(ei), 32'(irq));
   endtask : run

   task automatic test_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(AXI_CTL, d, r);
      chk("ctl reset", 32'(CTL_RESET), d);
      axi_rd(8'h40, d, r);
      chk("unmapped read", 32'(RESP_SLVERR), 32'(r));
      axi_wr(8'h40, 32'h000000FF, r);
      chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
      cfg(8'h00, 1'b0);
      repeat (100) @(posedge core_clk);
      cmd(32'h00000020);
      axi_rd(AXI_COUNT, d, r);
      chk("held count", 32'h0000FFF0, {16'h0000, d[15:0]});
   endtask : test_regs

   task automatic test_baud_dirs;
      run(8'h00, 1'b0, 0, 0, 0, 1'b0);
      run(SETUP_BAUD_BOTH_INT, 1'b0, 60, 1, 1, 1'b0);
      run(SETUP_BAUD_RX_INT, 1'b0, 60, 0, 1, 1'b0);
      run(SETUP_BAUD_TX_INT, 1'b0, 60, 1, 0, 1'b0);
   endtask : test_baud_dirs

   task automatic test_twelve;
      run(SETUP_BAUD_BOTH_INT, 1'b1, 30, 1, 1, 1'b0);
      run(SETUP_RELOAD_INT | 8'h04, 1'b1, 5, 0, 0, 1'b1);
   endtask : test_twelve

   // capture keeps the count below 100h, so an uncaptured reload shows FF
   task automatic test_trigger;
      logic [31:0] d;
      logic [1:0]  r;
      run(SETUP_BAUD_BOTH_INT | 8'h08, 1'b0, 60, 1, 1, 1'b1);
      run(SETUP_RELOAD_EXT | 8'h04, 1'b0, 0, 0, 0, 1'b1);
      run(SETUP_CAPTURE_EXT | 8'h04, 1'b0, 0, 0, 0, 1'b1);
      cmd(32'h00000020);
      axi_rd(AXI_CAPTURE, d, r);
      chk("capture high", 32'h00000000, {24'h000000, d[15:8]});
   endtask : test_trigger

   task automatic test_modes;
      run(SETUP_RELOAD_INT | 8'h04, 1'b0, 10, 0, 0, 1'b1);
      run(SETUP_CAPTURE_INT | 8'h04, 1'b0, 0, 0, 0, 1'b1);
      run(8'h06, 1'b0, 3, 0, 0, 1'b1);
      run(SETUP_BAUD_BOTH_EXT, 1'b0, 3, 1, 1, 1'b0);
   endtask : test_modes

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'b1;
      test_regs();
      test_baud_dirs();
      test_twelve();
      test_trigger();
      test_modes();
      print_verdict();
   end

   // about 16k cycles expected; cut a hang well past that
   initial begin
      repeat (40000) @(posedge core_clk);
      miscompares++;
      print_verdict();
   end
endmodule : tmbg_tb_top
